// file: core/sdc_top.sv
// Control, chopping and protection logic of a two-channel stepper driver.
// Notes on behaviour
// RULE1: brake forces full level, phase picks direction
// RULE2: standby low removes bias, high runs
// RULE3: entering standby clears latched fault
// RULE4: host waits wake-up interval after standby
// RULE5: fault output pulls low on fault
// RULE6: fault holds until supply cycle or standby
// RULE7: thermal warning follows alarm, auto release
// RULE8: phase reversal inserts both-off dead time
// RULE9: fixed off time programmable five to forty
// RULE10: chopping disabled when reference tied high
// RULE11: brake high on, low normal
// RULE12: brake without chopping turns all on
// RULE13: fault turns all transistors off
// RULE14: select bits encode current ratio
// RULE15: current trip starts fixed off time
// RULE16: standby keeps outputs off, monitors released
module sdc_top #(
  parameter int WAKE_CYC = sdc_pkg::WAKE_US * sdc_pkg::CYC_PER_US,
  parameter int US_CYC = sdc_pkg::CYC_PER_US
) (
  input wire logic CLK_IN,
  input wire logic RST_IN,
  input wire logic SLEEP_N_IN,
  input wire logic BRAKE_IN,
  input wire logic [1:0] PHASE_IN,
  input wire logic [1:0] CURRENT_LEVEL_SEL_HI_IN,
  input wire logic [1:0] CURRENT_LEVEL_SEL_LO_IN,
  input wire logic [1:0] CURRENT_TRIP_IN,
  input wire logic CHOP_DISABLE_IN,
  input wire logic OVERCURRENT_DETECT_IN,
  input wire logic THERMAL_SHUTDOWN_IN,
  input wire logic THERMAL_ALARM_IN,
  input wire logic MOTOR_SUPPLY_OK_IN,
  output logic [1:0] GATE_POS_OUT,
  output logic [1:0] GATE_NEG_OUT,
  output logic [3:0] LEVEL_OUT,
  output logic BIAS_EN_OUT,
  output logic FAULT_N_OUT,
  output logic FAULT_OE_OUT,
  output logic THERMAL_WARN_N_OUT,
  output logic THERMAL_WARN_OE_OUT,
  input wire logic [3:0] AVS_ADDRESS_IN,
  input wire logic AVS_READ_IN,
  input wire logic AVS_WRITE_IN,
  input wire logic [31:0] AVS_WRITEDATA_IN,
  output logic [31:0] AVS_READDATA_OUT,
  output logic AVS_WAITREQUEST_OUT
);
  import sdc_pkg::*;

  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  localparam int NP = 15;
  // Every pin passes two flops; stage one feeds only stage two.
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] s1_r;
  logic [NP-1:0] s2_r;
  assign pin_raw = {SLEEP_N_IN, BRAKE_IN, PHASE_IN, CURRENT_LEVEL_SEL_HI_IN,
    CURRENT_LEVEL_SEL_LO_IN, CURRENT_TRIP_IN, CHOP_DISABLE_IN,
    OVERCURRENT_DETECT_IN, THERMAL_SHUTDOWN_IN, THERMAL_ALARM_IN, MOTOR_SUPPLY_OK_IN};
  always_ff @(posedge CLK_IN)
  begin
    s1_r <= RST_IN ? '0 : pin_raw;
    s2_r <= RST_IN ? '0 : s1_r;
  end
  // Named views of the synchronised pins.
  logic sleep_n, brake, chop_dis, ocd, thermal_shutdown, alarm, supply_ok;
  logic [1:0] phase, sel_hi, sel_lo, trip;
  assign {sleep_n, brake, phase, sel_hi, sel_lo, trip, chop_dis,
    ocd, thermal_shutdown, alarm, supply_ok} = s2_r;

  // ==========================================================
  // Standby and wake-up
  // ==========================================================
  sdc_pwr_t pwr_r, pwr_nxt;
  logic [15:0] wake_r, wake_nxt;
  logic bias_r, bias_nxt;
  // Gates and levels stay off during the wake guard, since the host may not
  // change inputs then and the bias is still settling.
  always_comb
  begin
    pwr_nxt = pwr_r;
    wake_nxt = wake_r;
    bias_nxt = sleep_n; // see RULE2
    case (pwr_r)
      SDC_SLEEP:
      begin
        wake_nxt = 16'(WAKE_CYC);
        if (sleep_n)
          pwr_nxt = SDC_WAKE;
      end
      SDC_WAKE:
      begin
        // Count the guard down; a drop back to standby restarts it.
        wake_nxt = wake_r - 16'h0001;
        if (!sleep_n)
          pwr_nxt = SDC_SLEEP;
        else if (wake_r <= 16'h0001)
          pwr_nxt = SDC_RUN; // see RULE4
      end
      SDC_RUN:
      begin
        if (!sleep_n)
          pwr_nxt = SDC_SLEEP; // see RULE2
      end
      default:
        pwr_nxt = SDC_SLEEP;
    endcase
  end
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      pwr_r <= SDC_SLEEP;
      wake_r <= 16'h0000;
      bias_r <= 1'b0;
    end
    else
    begin
      pwr_r <= pwr_nxt;
      wake_r <= wake_nxt;
      bias_r <= bias_nxt;
    end
  end
  logic awake;
  assign awake = (pwr_r == SDC_RUN);

  // ==========================================================
  // Fault latch and monitor pins
  // ==========================================================
  logic fault_r, fault_nxt, warn_r, warn_nxt;
  // Standby or a supply drop clears the latch; detection needs bias,
  // so the clear wins here by construction.
  always_comb
  begin
    if (!sleep_n || !supply_ok)
      fault_nxt = 1'b0; // see RULE3, RULE6
    else
      fault_nxt = fault_r | (awake & (ocd | thermal_shutdown)); // see RULE5
    warn_nxt = sleep_n & alarm; // see RULE7, RULE16
  end
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      fault_r <= 1'b0;
      warn_r <= 1'b0;
    end
    else
    begin
      fault_r <= fault_nxt;
      warn_r <= warn_nxt;
    end
  end
  // Open-drain pins only ever drive low.
  assign FAULT_N_OUT = 1'b0;
  assign THERMAL_WARN_N_OUT = 1'b0;
  assign FAULT_OE_OUT = fault_r;
  assign THERMAL_WARN_OE_OUT = warn_r;
  assign BIAS_EN_OUT = bias_r;

  // ==========================================================
  // Register bus
  // ==========================================================
  logic [5:0] off_us_r, off_us_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rd_r, rd_nxt;
  logic req;
  assign req = AVS_READ_IN | AVS_WRITE_IN;
  // Each request is answered one cycle after it is seen.
  always_comb
  begin
    off_us_nxt = off_us_r;
    wait_nxt = 1'b1;
    rd_nxt = rd_r;
    if (req && wait_r)
    begin
      wait_nxt = 1'b0;
      rd_nxt = 32'h0000_0000;
      if (AVS_ADDRESS_IN == ADDR_CTRL)
        rd_nxt[5:0] = off_us_r;
      else if (AVS_ADDRESS_IN == ADDR_STATUS)
        rd_nxt[5:0] = {brake, chop_dis, ~sleep_n, awake, warn_r, fault_r};
    end
    // Writes land on the accepting edge; out-of-range values clamp.
    if (AVS_WRITE_IN && !wait_r && AVS_ADDRESS_IN == ADDR_CTRL)
    begin
      if (AVS_WRITEDATA_IN[31:0] < 32'(OFF_US_MIN))
        off_us_nxt = OFF_US_MIN; // see RULE9
      else if (AVS_WRITEDATA_IN[31:0] > 32'(OFF_US_MAX))
        off_us_nxt = OFF_US_MAX;
      else
        off_us_nxt = AVS_WRITEDATA_IN[5:0];
    end
  end
  always_ff @(posedge CLK_IN)
  begin
    if (RST_IN)
    begin
      off_us_r <= OFF_US_RST;
      wait_r <= 1'b1;
      rd_r <= 32'h0000_0000;
    end
    else
    begin
      off_us_r <= off_us_nxt;
      wait_r <= wait_nxt;
      rd_r <= rd_nxt;
    end
  end
  assign AVS_WAITREQUEST_OUT = wait_r;
  assign AVS_READDATA_OUT = rd_r;

  // ==========================================================
  // Channel drive and chopping
  // ==========================================================
  logic run;
  assign run = awake & ~fault_r; // see RULE13, RULE16
  logic [15:0] off_load;
  assign off_load = 16'(off_us_r * US_CYC);
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++)
    begin : g_ch
      logic ph_q_r, ph_q_nxt, gp_r, gp_nxt, gn_r, gn_nxt;
      logic [7:0] dead_r, dead_nxt;
      logic [15:0] off_r, off_nxt;
      logic [1:0] lvl, lvl_r, lvl_nxt;
      always_comb
      begin
        // Brake overrides the select bits at full scale.
        lvl = brake ? LVL_FULL : {sel_hi[ch], sel_lo[ch]}; // see RULE1, RULE11, RULE14
        ph_q_nxt = phase[ch];
        dead_nxt = 8'h00;
        if (phase[ch] != ph_q_r && awake)
          dead_nxt = 8'(DEAD_CYC); // see RULE8
        else if (dead_r != 8'h00)
          dead_nxt = dead_r - 8'h01;
        off_nxt = 16'h0000;
        if (off_r != 16'h0000 && !chop_dis)
          off_nxt = off_r - 16'h0001;
        else if (trip[ch] && !chop_dis && (gp_r | gn_r))
          off_nxt = off_load; // see RULE15, RULE10
        if (brake && chop_dis)
        begin
          gp_nxt = run; // see RULE12
          gn_nxt = run;
        end
        else
        begin
          gp_nxt = run & (lvl != LVL_ZERO) & (dead_nxt == 8'h00) & (off_nxt == 16'h0000) & phase[ch];
          gn_nxt = run & (lvl != LVL_ZERO) & (dead_nxt == 8'h00) & (off_nxt == 16'h0000) & ~phase[ch];
        end
        lvl_nxt = run ? lvl : LVL_ZERO;
      end
      always_ff @(posedge CLK_IN)
      begin
        if (RST_IN)
        begin
          ph_q_r <= 1'b0;
          dead_r <= 8'h00;
          off_r <= 16'h0000;
          gp_r <= 1'b0;
          gn_r <= 1'b0;
          lvl_r <= LVL_ZERO;
        end
        else
        begin
          ph_q_r <= ph_q_nxt;
          dead_r <= dead_nxt;
          off_r <= off_nxt;
          gp_r <= gp_nxt;
          gn_r <= gn_nxt;
          lvl_r <= lvl_nxt;
        end
      end
      assign GATE_POS_OUT[ch] = gp_r;
      assign GATE_NEG_OUT[ch] = gn_r;
      assign LEVEL_OUT[2*ch+1:2*ch] = lvl_r;

      // ========================================================
      // Checks per channel
      // ========================================================
      chk_brake_full_level: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE1
        (brake && run) |=> (lvl_r == LVL_FULL))
        else $error("Brake did not force full level.");
      chk_phase_dead_off: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE8
        (phase[ch] != ph_q_r && !(brake && chop_dis)) |=> (!gp_r && !gn_r)[*8])
        else $error("Gate driven inside dead time.");
      chk_dead_time_ends: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE8
        (phase[ch] != ph_q_r) |=> ##[1:80] (dead_r == 8'h00))
        else $error("Dead time too long.");
      chk_zero_level_off: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE14
        (!brake && !sel_hi[ch] && !sel_lo[ch]) |=> (!gp_r && !gn_r))
        else $error("Zero level still drives.");
      chk_trip_off_time: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE15
        (off_r == 16'h0000 && trip[ch] && !chop_dis && (gp_r || gn_r)) |=> (!gp_r && !gn_r)[*5])
        else $error("Trip did not start off time.");
      chk_no_shoot: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE12
        (gp_r && gn_r) |-> $past(brake && chop_dis))
        else $error("Both gates on without brake.");
      chk_chop_disabled: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE10
        chop_dis |=> (off_r == 16'h0000))
        else $error("Chopping while disabled.");
      cov_off_time: cover property (@(posedge CLK_IN) disable iff (RST_IN)
        (off_r == 16'h0001) ##1 (gp_r || gn_r));
    end
  endgenerate

  // ==========================================================
  // Checks across the block
  // ==========================================================
  chk_sleep_clears: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE3
    !sleep_n |=> !fault_r && !FAULT_OE_OUT)
    else $error("Standby did not clear fault.");
  chk_sleep_quiet: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE16
    !sleep_n |=> ##1 (GATE_POS_OUT == 2'h0 && GATE_NEG_OUT == 2'h0 && !THERMAL_WARN_OE_OUT))
    else $error("Standby left outputs active.");
  chk_fault_kills: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE13
    fault_r |=> (GATE_POS_OUT == 2'h0 && GATE_NEG_OUT == 2'h0))
    else $error("Fault left a gate on.");
  chk_fault_holds: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE6
    (fault_r && sleep_n && supply_ok) |=> fault_r)
    else $error("Fault released early.");
  chk_fault_sets: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE5
    (awake && ocd && sleep_n && supply_ok) |=> FAULT_OE_OUT)
    else $error("Fault not reported.");
  chk_warn_follow: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE7
    (sleep_n && alarm) ##1 !alarm |=> !THERMAL_WARN_OE_OUT)
    else $error("Warning did not release.");
  chk_bias_level: assert property (@(posedge CLK_IN) disable iff (RST_IN) // see RULE2
    $rose(sleep_n) |=> BIAS_EN_OUT ##1 !awake)
    else $error("Bias or wake guard wrong.");
  cov_wake: cover property (@(posedge CLK_IN) disable iff (RST_IN) $rose(awake));
  cov_fault: cover property (@(posedge CLK_IN) disable iff (RST_IN) $rose(fault_r));
  cov_brake_all: cover property (@(posedge CLK_IN) disable iff (RST_IN)
    GATE_POS_OUT == 2'h3 && GATE_NEG_OUT == 2'h3);
endmodule

// file: core/sdc_pkg.sv
// Shared constants for the stepper driver control and protection block.
package sdc_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  // Core clock in kHz (8 ns period).
  localparam int CLK_KHZ = 125000;
  // Internal system oscillator in kHz.
  localparam int SYS_OSC_KHZ = 6400;
  // Phase reversal dead time in oscillator cycles.
  localparam int DEAD_OSC_CLK = 3;
  // Dead time in core cycles, rounded up.
  localparam int DEAD_CYC = (DEAD_OSC_CLK * CLK_KHZ + SYS_OSC_KHZ - 1) / SYS_OSC_KHZ;
  // Wake-up guard after leaving standby, in microseconds.
  localparam int WAKE_US = 10;
  // Core cycles per microsecond, rounded down.
  localparam int CYC_PER_US = CLK_KHZ / 1000;
  // Fixed off time range and reset value, in microseconds.
  localparam logic [5:0] OFF_US_MIN = 6'h05;
  localparam logic [5:0] OFF_US_MAX = 6'h28;
  localparam logic [5:0] OFF_US_RST = 6'h0A;
  // ==========================================================
  // Register map (byte addresses)
  // ==========================================================
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  // Status bit positions.
  localparam int ST_FAULT = 0;
  localparam int ST_WARN = 1;
  localparam int ST_AWAKE = 2;
  localparam int ST_SLEEP = 3;
  localparam int ST_CHOP_OFF = 4;
  localparam int ST_BRAKE = 5;
  // ==========================================================
  // Current levels
  // ==========================================================
  localparam logic [1:0] LVL_ZERO = 2'h0;
  localparam logic [1:0] LVL_FULL = 2'h3;
  // Standby state machine.
  typedef enum logic [1:0] {
    SDC_SLEEP = 2'b00,
    SDC_WAKE = 2'b01,
    SDC_RUN = 2'b10
  } sdc_pwr_t;
endpackage

// file: testbench/sdc_host_model.sv
// Host controller model driving the control pins and pulling up both monitor lines.
module sdc_host_model #(
  parameter int GUARD_CYC = 24
) (
  input wire logic clk_in,
  input wire logic fault_n_in,
  input wire logic fault_oe_in,
  input wire logic warn_n_in,
  input wire logic warn_oe_in,
  output logic sleep_n_out,
  output logic brake_out,
  output logic [1:0] phase_out,
  output logic [1:0] sel_hi_out,
  output logic [1:0] sel_lo_out,
  output logic fault_line_out,
  output logic warn_line_out
);
  // ==========================================================
  // Pins
  // ==========================================================
  // Both channels start on the positive side, so the first drive causes no reversal.
  initial
  begin
    sleep_n_out = 1'b0;
    brake_out = 1'b0;
    phase_out = 2'h3;
    sel_hi_out = 2'h0;
    sel_lo_out = 2'h0;
  end
  // Pull-up resistors: a released line reads high, never the last driven value.
  assign fault_line_out = fault_oe_in ? fault_n_in : 1'b1;
  assign warn_line_out = warn_oe_in ? warn_n_in : 1'b1;
  // Leave standby, then keep every other pin still through the wake-up guard.
  task wake;
    @(posedge clk_in);
    sleep_n_out <= 1'b1;
    repeat (GUARD_CYC) @(posedge clk_in);
  endtask
  // Enter standby and give the synchroniser time to carry it.
  task sleep;
    @(posedge clk_in);
    sleep_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
  endtask
  // Change brake, phase and both level selects together.
  task drive(input logic brk, input logic [1:0] ph, input logic [1:0] hi, input logic [1:0] lo);
    @(posedge clk_in);
    brake_out <= brk;
    phase_out <= ph;
    sel_hi_out <= hi;
    sel_lo_out <= lo;
  endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench of the stepper driver control and protection block.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sdc_pkg::*;
  // Short wake guard and a 2-cycle microsecond keep the run brief.
  localparam int WAKE_T = 20;
  localparam int US_T = 2;
  logic clk, rst, chop, ocd, thermal_shutdown, alarm, sup_ok, rd, wr, bias, fn, foe, wn, woe, waitreq, fline, wline;
  logic slp_n, brk;
  logic [1:0] ph, hi, lo, trip, gp, gn;
  logic [3:0] addr, lvl;
  logic [31:0] wdata, rdata;
  logic [5:0] mon;
  int err_total = 0;
  int total_checks = 0;
  // Watched bits: gate pos A,B, gate neg A,B, fault line, warning line.
  assign mon = {wline, fline, gn, gp};
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  sdc_top #(.WAKE_CYC(WAKE_T), .US_CYC(US_T)) dut (.CLK_IN(clk), .RST_IN(rst), .SLEEP_N_IN(slp_n),
    .BRAKE_IN(brk), .PHASE_IN(ph), .CURRENT_LEVEL_SEL_HI_IN(hi), .CURRENT_LEVEL_SEL_LO_IN(lo),
    .CURRENT_TRIP_IN(trip), .CHOP_DISABLE_IN(chop), .OVERCURRENT_DETECT_IN(ocd), .THERMAL_SHUTDOWN_IN(thermal_shutdown),
    .THERMAL_ALARM_IN(alarm), .MOTOR_SUPPLY_OK_IN(sup_ok), .GATE_POS_OUT(gp), .GATE_NEG_OUT(gn),
    .LEVEL_OUT(lvl), .BIAS_EN_OUT(bias), .FAULT_N_OUT(fn), .FAULT_OE_OUT(foe), .THERMAL_WARN_N_OUT(wn),
    .THERMAL_WARN_OE_OUT(woe), .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
    .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata), .AVS_WAITREQUEST_OUT(waitreq));
  sdc_host_model #(.GUARD_CYC(WAKE_T + 4)) host (.clk_in(clk), .fault_n_in(fn), .fault_oe_in(foe),
    .warn_n_in(wn), .warn_oe_in(woe), .sleep_n_out(slp_n), .brake_out(brk), .phase_out(ph),
    .sel_hi_out(hi), .sel_lo_out(lo), .fault_line_out(fline), .warn_line_out(wline));
  // ==========================================================
  // Shared tasks
  // ==========================================================
  // Print the counts and the verdict, then stop.
  task complete_run;
    $display("Checks %0d, errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Compare one value, four-state exact.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Count falling edges until a watched bit takes a value; a hang ends the run.
  task wait_bit(input int b, input logic v, output int n);
    n = 0;
    while (mon[b] !== v)
    begin
      @(negedge clk);
      n++;
      if (n > 2000)
      begin
        err_total++;
        $display("ERROR t=%0t got=%h exp=%h", $time, mon[b], v);
        complete_run();
      end
    end
  endtask
  // One Avalon transfer; the request holds until the rising edge that samples waitrequest low, and read
  // data is taken at that same edge before the release.
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int i;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    rd <= !w;
    wr <= w;
    for (i = 0; i < 50; i++)
    begin
      @(posedge clk);
      if (waitreq === 1'b0)
        break;
    end
    if (i == 50)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, waitreq, 1'b0);
      complete_run();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task settle(input int c);
    repeat (c) @(negedge clk);
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task t_regs;
    logic [31:0] q;
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    chk(q, 32'h0000000A);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk(q, 32'h00000008);
    chk(bias, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h00000003, q);
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    chk(q, {26'h0, OFF_US_MIN});
    bus(1'b1, ADDR_CTRL, 32'h0000003F, q);
    bus(1'b0, ADDR_CTRL, 32'h0, q);
    chk(q, {26'h0, OFF_US_MAX});
    // An unmapped write is answered but lands nowhere.
    bus(1'b1, 4'h8, 32'hFFFFFFFF, q);
    bus(1'b0, 4'h8, 32'h0, q);
    chk(q, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h00000005, q);
  endtask
  task t_wake;
    logic [31:0] q;
    host.wake();
    chk(bias, 1'b1);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk(q, 32'h00000004);
  endtask
  // Every level code on both channels; code zero must leave the gates off.
  task t_levels;
    int c;
    for (c = 0; c < 4; c++)
    begin
      host.drive(1'b0, 2'h3, {2{c[1]}}, {2{c[0]}});
      settle(6);
      chk(lvl, {2{c[1:0]}});
      chk({gn, gp}, (c == 0) ? 4'h0 : 4'h3);
    end
  endtask
  task t_brake;
    logic [31:0] q;
    host.drive(1'b1, 2'h1, 2'h0, 2'h0);
    settle(80);
    chk(lvl, 4'hF);
    chk({gn, gp}, 4'h9);
    host.drive(1'b0, 2'h1, 2'h0, 2'h0);
    settle(6);
    chk(lvl, 4'h0);
    @(posedge clk);
    chop <= 1'b1;
    host.drive(1'b1, 2'h1, 2'h0, 2'h0);
    settle(6);
    chk({gn, gp}, 4'hF);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk(q, 32'h00000034);
    chop <= 1'b0;
    host.drive(1'b0, 2'h3, 2'h3, 2'h3);
    settle(80);
  endtask
  task t_dead;
    int n;
    host.drive(1'b0, 2'h2, 2'h3, 2'h3);
    wait_bit(0, 1'b0, n);
    wait_bit(2, 1'b1, n);
    chk(n, DEAD_CYC);
    chk(gp[1], 1'b1);
  endtask
  task t_trip;
    int n;
    @(posedge clk);
    trip <= 2'h1;
    wait_bit(2, 1'b0, n);
    @(posedge clk);
    trip <= 2'h0;
    wait_bit(2, 1'b1, n);
    chk(n, 5 * US_T);
    @(posedge clk);
    chop <= 1'b1;
    trip <= 2'h1;
    settle(8);
    chk(gn[0], 1'b1);
    @(posedge clk);
    trip <= 2'h0;
    chop <= 1'b0;
  endtask
  task t_fault;
    int n;
    logic [31:0] q;
    @(posedge clk);
    ocd <= 1'b1;
    wait_bit(4, 1'b0, n);
    settle(2);
    chk({gn, gp}, 4'h0);
    @(posedge clk);
    ocd <= 1'b0;
    settle(10);
    chk(fline, 1'b0);
    bus(1'b0, ADDR_STATUS, 32'h0, q);
    chk(q, 32'h00000005);
    host.sleep();
    chk(fline, 1'b1);
    chk({bias, gn, gp}, 5'h0);
    host.wake();
    @(posedge clk);
    thermal_shutdown <= 1'b1;
    wait_bit(4, 1'b0, n);
    @(posedge clk);
    thermal_shutdown <= 1'b0;
    sup_ok <= 1'b0;
    wait_bit(4, 1'b1, n);
    @(posedge clk);
    sup_ok <= 1'b1;
    settle(10);
    chk(fline, 1'b1);
  endtask
  // The warning follows the alarm both ways and is released in standby.
  task t_warn;
    int n;
    @(posedge clk);
    alarm <= 1'b1;
    wait_bit(5, 1'b0, n);
    @(posedge clk);
    alarm <= 1'b0;
    wait_bit(5, 1'b1, n);
    @(posedge clk);
    alarm <= 1'b1;
    host.sleep();
    settle(4);
    chk(wline, 1'b1);
  endtask
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial
  begin
    rst = 1'b1;
    chop = 1'b0;
    ocd = 1'b0;
    thermal_shutdown = 1'b0;
    alarm = 1'b0;
    sup_ok = 1'b1;
    trip = 2'h0;
    addr = 4'h0;
    rd = 1'b0;
    wr = 1'b0;
    wdata = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_wake();
    t_levels();
    t_brake();
    t_dead();
    t_trip();
    t_fault();
    t_warn();
    complete_run();
  end
endmodule
